// [hw/bus_cycle_select_clock_stop.sv]
// Bus cycle generator, address source selection and processor clock stop
// Operation
// - Three separately enabled processor clock stops: halt, other master, expansion cycle.
// - Halt stop begins on halt cycle; wake on master request, interrupt or NMI.
// - Master stop begins only after processor acknowledges the hold request.
// - Master holds request throughout ownership; clock stays stopped until it drops.
// - Expansion stop begins once cycle starts, ends when target signals ready.
// - Internal modules and external ISA targets are run with ISA timing.
// - Each cycle sets 24-bit address and 16-bit data to target's format.
// - Hardware splits transfers to match target data width, no software.
// - One shared address/data bus; separate strobes for memory, expansion, card.
// - Memory mapper watches raw address, card mapper latched address; both claim.
// - Unclaimed cycle runs ISA timing with latched address on low pins.
// - When both claim, memory mapper wins and card cycle is suppressed.
`timescale 1ns/1ns
module bus_cycle_select_clock_stop
    import bus_cycle_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic clk_en_i,
    input wire logic [bus_cycle_pkg::REG_AW-1:0] reg_addr_i,
    input wire logic [bus_cycle_pkg::REG_DW-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [bus_cycle_pkg::REG_DW-1:0] reg_rdata_o,
    input wire bus_cycle_pkg::cyc_req_s cyc_req_i,
    input wire logic halt_cycle_i,
    input wire bus_cycle_pkg::map_claim_s mem_map_i,
    input wire bus_cycle_pkg::map_claim_s card_map_i,
    input wire logic isa_wide_i,
    input wire logic ready_i,
    input wire logic hold_request_i,
    input wire logic hold_acknowledge_i,
    input wire logic intr_i,
    input wire logic nmi_i,
    output logic proc_clk_run_o,
    output logic [bus_cycle_pkg::ADDR_W-1:0] ext_addr_o,
    output logic mem_strobe_o,
    output logic isa_strobe_o,
    output logic card_strobe_o,
    output logic int_strobe_o,
    output logic data_wide_o,
    output logic high_byte_o,
    output logic cycle_busy_o,
    output logic cycle_done_o
);
    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] serial_clk;
        logic [7:0] timer_clk_1;
        logic [7:0] timer_clk_2;
        logic [7:0] system_clk;
        logic [7:0] rdata;
        cyc_state_e state;
        target_e target;
        logic [ADDR_W-1:0] addr;
        logic [WAIT_W-1:0] wait_cnt;
        logic wide;
        logic split;
        logic high;
        logic mem_stb;
        logic isa_stb;
        logic card_stb;
        logic int_stb;
        logic done;
        logic busy;
    } core_s;

    core_s st_reg;
    core_s st_next;
    target_e sel_target;
    logic [ADDR_W-1:0] sel_addr;
    logic sel_wide;
    logic [2:0] stop_reason;
    logic exp_start;

    address_select u_select (
        .req_i(cyc_req_i),
        .mem_map_i(mem_map_i),
        .card_map_i(card_map_i),
        .isa_wide_i(isa_wide_i),
        .target_o(sel_target),
        .addr_o(sel_addr),
        .wide_o(sel_wide)
    );

    // expansion stop armed as the cycle launches
    assign exp_start = (st_reg.state == CYC_ADDR) && (st_reg.target == TGT_ISA)
        && !st_reg.high;

    clock_stop_ctrl u_stop (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .clk_en_i(clk_en_i),
        .stop_en_i(st_reg.mode[2:0]),
        .halt_seen_i(halt_cycle_i),
        .hold_request_i(hold_request_i),
        .hold_acknowledge_i(hold_acknowledge_i),
        .exp_start_i(exp_start),
        .ready_i(ready_i),
        .intr_i(intr_i),
        .nmi_i(nmi_i),
        .run_o(proc_clk_run_o),
        .reason_o(stop_reason)
    );

    always_comb begin
        st_next = st_reg;
        st_next.done = 1'b0;
        // Register writes
        if (reg_wr_i) begin
            case (reg_addr_i)
                OFS_MODE: begin
                    st_next.mode = reg_wdata_i;
                end
                OFS_SERIAL_CLK: begin
                    st_next.serial_clk = reg_wdata_i;
                end
                OFS_TIMER_CLK_1: begin
                    st_next.timer_clk_1 = reg_wdata_i;
                end
                OFS_TIMER_CLK_2: begin
                    st_next.timer_clk_2 = reg_wdata_i;
                end
                OFS_SYSTEM_CLK: begin
                    st_next.system_clk = reg_wdata_i;
                end
                default: begin
                end
            endcase
        end
        // Read data stands only in the cycle after the strobe
        st_next.rdata = 8'h00;
        if (reg_rd_i) begin
            case (reg_addr_i)
                OFS_MODE: begin
                    st_next.rdata = st_reg.mode;
                end
                OFS_SERIAL_CLK: begin
                    st_next.rdata = st_reg.serial_clk;
                end
                OFS_TIMER_CLK_1: begin
                    st_next.rdata = st_reg.timer_clk_1;
                end
                OFS_TIMER_CLK_2: begin
                    st_next.rdata = st_reg.timer_clk_2;
                end
                OFS_SYSTEM_CLK: begin
                    st_next.rdata = st_reg.system_clk;
                end
                OFS_STATUS: begin
                    st_next.rdata = {2'h0, st_reg.target, st_reg.high, stop_reason};
                end
                default: begin
                    st_next.rdata = 8'h00;
                end
            endcase
        end
        // Cycle generator
        case (st_reg.state)
            CYC_IDLE: begin
                if (cyc_req_i.start) begin
                    st_next.target = sel_target;
                    // address and width set per cycle
                    st_next.addr = sel_addr;
                    st_next.wide = sel_wide && cyc_req_i.word;
                    // word to byte-wide target is split in two
                    st_next.split = cyc_req_i.word && !sel_wide;
                    st_next.high = 1'b0;
                    st_next.busy = 1'b1;
                    st_next.state = CYC_ADDR;
                end
            end
            CYC_ADDR: begin
                st_next.mem_stb = (st_reg.target == TGT_MEM);
                st_next.isa_stb = (st_reg.target == TGT_ISA);
                st_next.card_stb = (st_reg.target == TGT_CARD);
                st_next.int_stb = (st_reg.target == TGT_INT);
                // ISA wait states for all but mapped memory
                if (st_reg.target == TGT_MEM) begin
                    st_next.wait_cnt = MEM_WAIT;
                end else begin
                    st_next.wait_cnt = st_reg.mode[MODE_WAIT_LSB +: WAIT_W];
                end
                st_next.state = CYC_CMD;
            end
            CYC_CMD: begin
                if (st_reg.wait_cnt != 3'h0) begin
                    st_next.wait_cnt = st_reg.wait_cnt - 3'h1;
                end else if (ready_i) begin
                    st_next.mem_stb = 1'b0;
                    st_next.isa_stb = 1'b0;
                    st_next.card_stb = 1'b0;
                    st_next.int_stb = 1'b0;
                    // second byte follows at next address
                    if (st_reg.split && !st_reg.high) begin
                        st_next.high = 1'b1;
                        st_next.addr = st_reg.addr + 24'h000001;
                        st_next.state = CYC_ADDR;
                    end else begin
                        st_next.state = CYC_END;
                    end
                end
            end
            CYC_END: begin
                st_next.done = 1'b1;
                st_next.busy = 1'b0;
                st_next.state = CYC_IDLE;
            end
            default: begin
                st_next.state = CYC_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_reg <= '{
                mode: MODE_RESET,
                serial_clk: CLK_CTRL_RESET,
                timer_clk_1: CLK_CTRL_RESET,
                timer_clk_2: CLK_CTRL_RESET,
                system_clk: CLK_CTRL_RESET,
                rdata: 8'h00,
                state: CYC_IDLE,
                target: TGT_ISA,
                addr: 24'h000000,
                wait_cnt: 3'h0,
                default: 1'b0
            };
        end else if (clk_en_i) begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata_o = st_reg.rdata;
    assign ext_addr_o = st_reg.addr;
    assign mem_strobe_o = st_reg.mem_stb;
    assign isa_strobe_o = st_reg.isa_stb;
    assign card_strobe_o = st_reg.card_stb;
    assign int_strobe_o = st_reg.int_stb;
    assign data_wide_o = st_reg.wide;
    assign high_byte_o = st_reg.high;
    // Busy has its own flop so the pin never sees a state decode glitch
    assign cycle_busy_o = st_reg.busy;
    assign cycle_done_o = st_reg.done;

    a_one_strobe: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $onehot0({mem_strobe_o, isa_strobe_o, card_strobe_o, int_strobe_o}))
        else $error("more than one sub-bus strobe active");
    a_mem_priority: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        cyc_req_i.mem && !cyc_req_i.internal && mem_map_i.claim |-> sel_target == TGT_MEM)
        else $error("memory claim not selected");
    a_mem_wins: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        clk_en_i && st_reg.state == CYC_IDLE && cyc_req_i.start && cyc_req_i.mem
        && !cyc_req_i.internal && mem_map_i.claim |=> st_reg.target == TGT_MEM)
        else $error("memory mapper claim lost");
    a_isa_default: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        clk_en_i && st_reg.state == CYC_IDLE && cyc_req_i.start && !cyc_req_i.internal
        && !(cyc_req_i.mem && (mem_map_i.claim || card_map_i.claim))
        |=> st_reg.target == TGT_ISA && ext_addr_o[19:0] == $past(cyc_req_i.latched))
        else $error("unclaimed cycle not sent as ISA with latched address");
    a_split_high: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        clk_en_i && $rose(high_byte_o) |-> ext_addr_o == $past(ext_addr_o) + 24'h000001)
        else $error("second byte not at next address");
    a_ready_ends: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        clk_en_i && st_reg.state == CYC_CMD && st_reg.wait_cnt == 3'h0 && ready_i
        |=> !mem_strobe_o && !isa_strobe_o && !card_strobe_o && !int_strobe_o)
        else $error("strobe stayed after ready");
    a_wait_isa: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        clk_en_i && st_reg.state == CYC_ADDR && st_reg.target != TGT_MEM
        |=> st_reg.wait_cnt == $past(st_reg.mode[MODE_WAIT_LSB +: WAIT_W]))
        else $error("ISA-timed cycle lost its wait states");
    a_exp_stop: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        clk_en_i && exp_start && st_reg.mode[MODE_EXP_BIT] && !ready_i
        |=> !proc_clk_run_o)
        else $error("expansion cycle did not stop the processor clock");
    a_halt_stop: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        clk_en_i && st_reg.mode[MODE_HALT_BIT] && halt_cycle_i
        && !hold_request_i && !intr_i && !nmi_i |=> !proc_clk_run_o)
        else $error("halt cycle did not stop the processor clock");
    a_hold_stop: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        clk_en_i && st_reg.mode[MODE_HOLD_BIT] && hold_request_i && hold_acknowledge_i
        |=> !proc_clk_run_o)
        else $error("acknowledged hold did not stop the clock");
    a_start_refused: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        clk_en_i && st_reg.state != CYC_IDLE && cyc_req_i.start
        |=> st_reg.target == $past(st_reg.target))
        else $error("start taken while busy");
    a_busy_flag: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        cycle_busy_o == (st_reg.state != CYC_IDLE))
        else $error("busy output disagrees with cycle state");
    a_read_lane: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        clk_en_i && !reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data outside the answer cycle");
endmodule // bus_cycle_select_clock_stop

// [hw/bus_cycle_pkg.sv]
// Constants, register map and carrier types for the bus cycle block
package bus_cycle_pkg;
    localparam int ADDR_W = 24;
    localparam int CPU_ADDR_W = 20;
    localparam int REG_AW = 8;
    localparam int REG_DW = 8;
    // Register offsets
    localparam logic [7:0] OFS_MODE = 8'h01;
    localparam logic [7:0] OFS_SERIAL_CLK = 8'h0f;
    localparam logic [7:0] OFS_TIMER_CLK_1 = 8'h12;
    localparam logic [7:0] OFS_TIMER_CLK_2 = 8'h13;
    localparam logic [7:0] OFS_SYSTEM_CLK = 8'hde;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    // Reset values
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] CLK_CTRL_RESET = 8'h00;
    // Mode register fields
    localparam int MODE_HALT_BIT = 0;
    localparam int MODE_HOLD_BIT = 1;
    localparam int MODE_EXP_BIT = 2;
    localparam int MODE_WAIT_LSB = 3;
    localparam int WAIT_W = 3;
    // Mapped memory is never stretched by the wait field
    localparam logic [2:0] MEM_WAIT = 3'h0;

    typedef enum logic [1:0] {
        CYC_IDLE = 2'b00,
        CYC_ADDR = 2'b01,
        CYC_CMD = 2'b11,
        CYC_END = 2'b10
    } cyc_state_e;

    typedef enum logic [1:0] {
        TGT_ISA = 2'h0,
        TGT_MEM = 2'h1,
        TGT_CARD = 2'h2,
        TGT_INT = 2'h3
    } target_e;

    typedef struct packed {
        logic start;
        logic mem;
        logic word;
        logic internal;
        logic [CPU_ADDR_W-1:0] raw;
        logic [CPU_ADDR_W-1:0] latched;
    } cyc_req_s;

    typedef struct packed {
        logic claim;
        logic wide;
        logic [ADDR_W-1:0] addr;
    } map_claim_s;
endpackage

// [hw/clock_stop_ctrl.sv]
// Processor clock stop control for halt, hold and expansion cycles
`timescale 1ns/1ns
module clock_stop_ctrl
    import bus_cycle_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic clk_en_i,
    input wire logic [2:0] stop_en_i,
    input wire logic halt_seen_i,
    input wire logic hold_request_i,
    input wire logic hold_acknowledge_i,
    input wire logic exp_start_i,
    input wire logic ready_i,
    input wire logic intr_i,
    input wire logic nmi_i,
    output logic run_o,
    output logic [2:0] reason_o
);
    typedef struct packed {
        logic halt;
        logic hold;
        logic exp;
        logic run;
    } stop_s;

    stop_s st_reg;
    stop_s st_next;
    logic wake;

    assign wake = hold_request_i | intr_i | nmi_i;

    always_comb begin
        st_next = st_reg;
        if (st_reg.halt && wake) begin
            st_next.halt = 1'b0;
        end else if (stop_en_i[MODE_HALT_BIT] && halt_seen_i && !wake) begin
            st_next.halt = 1'b1;
        end
        if (stop_en_i[MODE_HOLD_BIT] && hold_request_i && hold_acknowledge_i) begin
            st_next.hold = 1'b1;
        end else if (!hold_request_i) begin
            st_next.hold = 1'b0;
        end
        if (st_reg.exp && ready_i) begin
            st_next.exp = 1'b0;
        end else if (stop_en_i[MODE_EXP_BIT] && exp_start_i && !ready_i) begin
            st_next.exp = 1'b1;
        end
        // gate changes on whole clock edges
        st_next.run = !(st_next.halt || st_next.hold || st_next.exp);
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_reg <= '{halt: 1'b0, hold: 1'b0, exp: 1'b0, run: 1'b1};
        end else if (clk_en_i) begin
            st_reg <= st_next;
        end
    end

    assign run_o = st_reg.run;
    assign reason_o = {st_reg.exp, st_reg.hold, st_reg.halt};

    a_hold_released: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        clk_en_i && !hold_request_i |=> !st_reg.hold)
        else $error("hold stop outlived the hold request");
    a_hold_needs_ack: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $rose(st_reg.hold) |-> $past(hold_acknowledge_i))
        else $error("hold stop without acknowledge");
    a_halt_wake: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        clk_en_i && st_reg.halt && wake |=> !st_reg.halt)
        else $error("halt stop ignored a wake event");
    a_halt_pending: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        clk_en_i && !st_reg.halt && wake |=> !st_reg.halt)
        else $error("halt stop taken with wake pending");
    a_run_matches: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        run_o == (reason_o == 3'h0))
        else $error("run output disagrees with stop reasons");
endmodule // clock_stop_ctrl

// [hw/address_select.sv]
// Mapper arbitration and external address source selection
`timescale 1ns/1ns
module address_select
    import bus_cycle_pkg::*;
(
    input wire cyc_req_s req_i,
    input wire map_claim_s mem_map_i,
    input wire map_claim_s card_map_i,
    input wire logic isa_wide_i,
    output target_e target_o,
    output logic [ADDR_W-1:0] addr_o,
    output logic wide_o
);
    logic mem_claim;
    logic card_claim;

    assign mem_claim = req_i.mem && mem_map_i.claim;
    assign card_claim = req_i.mem && card_map_i.claim;

    always_comb begin
        target_o = TGT_ISA;
        wide_o = isa_wide_i;
        // unclaimed cycles use the latched address
        addr_o = {{(ADDR_W-CPU_ADDR_W){1'b0}}, req_i.latched};
        // internal modules take ISA timing too
        if (req_i.internal) begin
            target_o = TGT_INT;
            wide_o = 1'b1;
        end else if (mem_claim) begin
            target_o = TGT_MEM;
            wide_o = mem_map_i.wide;
            addr_o = mem_map_i.addr;
        end else if (card_claim) begin
            target_o = TGT_CARD;
            wide_o = card_map_i.wide;
            addr_o = card_map_i.addr;
        end
    end
endmodule // address_select

// [bench/target_model.sv]
// Expansion target model that answers each strobe with ready after a delay
`timescale 1ns/1ns
module target_model (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic strobe_i,
    input wire logic [3:0] delay_i,
    output logic ready_o
);
    logic [3:0] cnt_reg;
    // ready after delay
    // Ready clears on the edge after a strobe drops, so a stale ready never ends a new cycle
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_reg <= 4'h0;
            ready_o <= 1'b0;
        end else if (!strobe_i) begin
            cnt_reg <= 4'h0;
            ready_o <= 1'b0;
        end else begin
            cnt_reg <= cnt_reg + 4'h1;
            ready_o <= (cnt_reg >= delay_i);
        end
    end
endmodule // target_model

// [bench/tb_top.sv]
// Self-checking testbench for the bus cycle and clock stop block
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin n_compared++; if ((ex) !== (gt)) begin n_errors++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, gt); end end
module tb_top;
    import bus_cycle_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_rdata_o;
    cyc_req_s cyc_req_i = '0;
    logic halt_cycle_i = 1'b0;
    map_claim_s mem_map_i = '0;
    map_claim_s card_map_i = '0;
    logic isa_wide_i = 1'b0;
    logic ready_i;
    logic hold_request_i = 1'b0;
    logic hold_acknowledge_i = 1'b0;
    logic intr_i = 1'b0;
    logic nmi_i = 1'b0;
    logic clk_en = 1'b1;
    logic proc_clk_run_o, mem_strobe_o, isa_strobe_o, card_strobe_o, int_strobe_o;
    logic data_wide_o, high_byte_o, cycle_busy_o, cycle_done_o;
    logic [23:0] ext_addr_o;
    logic [3:0] delay = 4'h3;
    logic [3:0] strb;
    logic [23:0] a0, a1;
    logic hi_seen, card_seen, dw;
    logic [7:0] rd;
    int n_errors = 0;
    int n_compared = 0;
    int stopped, len, ticks = 0;

    always #10 ref_clk_i = ~ref_clk_i;

    bus_cycle_select_clock_stop i_dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
        .clk_en_i(clk_en), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .cyc_req_i(cyc_req_i), .halt_cycle_i(halt_cycle_i), .mem_map_i(mem_map_i),
        .card_map_i(card_map_i), .isa_wide_i(isa_wide_i), .ready_i(ready_i),
        .hold_request_i(hold_request_i), .hold_acknowledge_i(hold_acknowledge_i),
        .intr_i(intr_i), .nmi_i(nmi_i), .proc_clk_run_o(proc_clk_run_o),
        .ext_addr_o(ext_addr_o), .mem_strobe_o(mem_strobe_o), .isa_strobe_o(isa_strobe_o),
        .card_strobe_o(card_strobe_o), .int_strobe_o(int_strobe_o),
        .data_wide_o(data_wide_o), .high_byte_o(high_byte_o),
        .cycle_busy_o(cycle_busy_o), .cycle_done_o(cycle_done_o));

    target_model i_target (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
        .strobe_i(mem_strobe_o | isa_strobe_o | card_strobe_o | int_strobe_o),
        .delay_i(delay), .ready_o(ready_i));

    task automatic stop_test();
        $display("Errors %0d, comparisons %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Hang guard: the full sequence needs well under a thousand cycles
    always @(posedge ref_clk_i) begin
        ticks++;
        if (ticks == 5000) begin
            n_errors++;
            stop_test();
        end
    end

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    // One bus cycle; records strobes, addresses, split and clock stop count
    task automatic cyc(input logic mem, input logic word, input logic intl,
                       input logic [19:0] lat);
        logic seen;
        seen = 1'b0;
        hi_seen = 1'b0;
        card_seen = 1'b0;
        stopped = 0;
        @(posedge ref_clk_i);
        cyc_req_i <= '{1'b1, mem, word, intl, lat ^ 20'h00f0f, lat};
        @(posedge ref_clk_i);
        cyc_req_i.start <= 1'b0;
        for (int i = 0; i < 60; i++) begin
            @(posedge ref_clk_i);
            #1;
            if (proc_clk_run_o === 1'b0) stopped++;
            card_seen |= (card_strobe_o === 1'b1);
            if (!seen && {mem_strobe_o, isa_strobe_o, card_strobe_o, int_strobe_o} != 0) begin
                seen = 1'b1;
                strb = {mem_strobe_o, isa_strobe_o, card_strobe_o, int_strobe_o};
                a0 = ext_addr_o;
                dw = data_wide_o;
            end
            if (high_byte_o === 1'b1 && !hi_seen) begin
                hi_seen = 1'b1;
                a1 = ext_addr_o;
            end
            if (cycle_done_o === 1'b1) begin
                len = i;
                break;
            end
        end
        `CHK("cycle done", 1'b1, cycle_done_o)
        wait_n(1);
    endtask

    task automatic t_regs();
        logic [7:0] ofs [5] = '{OFS_MODE, OFS_SERIAL_CLK, OFS_TIMER_CLK_1,
                                OFS_TIMER_CLK_2, OFS_SYSTEM_CLK};
        for (int i = 0; i < 5; i++) begin
            reg_rd(ofs[i], rd);
            `CHK("reg reset", 8'h00, rd)
            reg_wr(ofs[i], 8'h38 + 8'(i));
            reg_rd(ofs[i], rd);
            `CHK("reg rw", 8'h38 + 8'(i), rd)
        end
        reg_wr(8'h55, 8'ha5);
        reg_rd(8'h55, rd);
        `CHK("unmapped", 8'h00, rd)
        reg_wr(OFS_STATUS, 8'hff);
        reg_rd(OFS_STATUS, rd);
        `CHK("status ro", 8'h00, rd)
        reg_wr(OFS_MODE, 8'h00);
    endtask

    task automatic t_select();
        logic [3:0] exp_s [4] = '{4'b0100, 4'b1000, 4'b0010, 4'b1000};
        mem_map_i.addr <= 24'hc12345;
        card_map_i.addr <= 24'h3c0abc;
        for (int k = 0; k < 4; k++) begin
            mem_map_i.claim <= k[0];
            card_map_i.claim <= k[1];
            cyc(1'b1, 1'b0, 1'b0, 20'hc0010 + 20'(k));
            `CHK("strobe", exp_s[k], strb)
            `CHK("no stop", 0, stopped)
            if (k == 0) `CHK("isa addr", 20'hc0010, a0[19:0])
            if (k[0]) `CHK("mem addr", 24'hc12345, a0)
            if (k == 2) `CHK("card addr", 24'h3c0abc, a0)
            if (k == 3) `CHK("card quiet", 1'b0, card_seen)
        end
        cyc(1'b0, 1'b0, 1'b0, 20'h00300);
        `CHK("io unmapped", 4'b0100, strb)
        mem_map_i.claim <= 1'b0;
        card_map_i.claim <= 1'b0;
        cyc(1'b0, 1'b0, 1'b1, 20'h00022);
        `CHK("internal", 4'b0001, strb)
    endtask

    task automatic t_size();
        isa_wide_i <= 1'b0;
        cyc(1'b1, 1'b1, 1'b0, 20'hd0100);
        `CHK("split hi", 1'b1, hi_seen)
        `CHK("split lo addr", 20'hd0100, a0[19:0])
        `CHK("split hi addr", 20'hd0101, a1[19:0])
        `CHK("split narrow", 1'b0, dw)
        isa_wide_i <= 1'b1;
        cyc(1'b1, 1'b1, 1'b0, 20'hd0200);
        `CHK("wide no split", 1'b0, hi_seen)
        `CHK("wide", 1'b1, dw)
        // Six edges with no waits and a ready delay of three; seven waits add three here
        reg_wr(OFS_MODE, 8'h38);
        cyc(1'b0, 1'b0, 1'b0, 20'h00310);
        `CHK("isa waits", 9, len)
        mem_map_i.claim <= 1'b1;
        cyc(1'b1, 1'b0, 1'b0, 20'hc0500);
        `CHK("mem no waits", 6, len)
        mem_map_i.claim <= 1'b0;
        reg_wr(OFS_MODE, 8'h00);
    endtask

    // A start while busy must be ignored
    task automatic t_refuse();
        cyc_req_i <= '{1'b1, 1'b0, 1'b0, 1'b0, 20'h0, 20'h00044};
        wait_n(1);
        cyc_req_i.start <= 1'b0;
        wait_n(2);
        cyc_req_i <= '{1'b1, 1'b0, 1'b0, 1'b0, 20'h0, 20'h00055};
        wait_n(1);
        cyc_req_i.start <= 1'b0;
        `CHK("busy", 1'b1, cycle_busy_o)
        wait_n(12);
        `CHK("refused start", 24'h000044, ext_addr_o)
        `CHK("idle", 1'b0, cycle_busy_o)
    endtask

    task automatic t_stops();
        reg_wr(OFS_MODE, 8'h04);
        cyc(1'b1, 1'b0, 1'b0, 20'hc0400);
        `CHK("exp stopped", 1'b1, stopped > 0)
        `CHK("exp resumed", 1'b1, proc_clk_run_o)
        reg_wr(OFS_MODE, 8'h03);
        hold_request_i <= 1'b1;
        wait_n(3);
        `CHK("no ack run", 1'b1, proc_clk_run_o)
        clk_en <= 1'b0;
        hold_acknowledge_i <= 1'b1;
        wait_n(3);
        `CHK("frozen", 1'b1, proc_clk_run_o)
        clk_en <= 1'b1;
        wait_n(2);
        `CHK("hold stop", 1'b0, proc_clk_run_o)
        reg_rd(OFS_STATUS, rd);
        `CHK("status hold", 8'h02, rd)
        hold_acknowledge_i <= 1'b0;
        wait_n(3);
        `CHK("hold kept", 1'b0, proc_clk_run_o)
        hold_request_i <= 1'b0;
        wait_n(2);
        `CHK("hold end", 1'b1, proc_clk_run_o)
        @(posedge ref_clk_i);
        halt_cycle_i <= 1'b1;
        @(posedge ref_clk_i);
        halt_cycle_i <= 1'b0;
        wait_n(3);
        `CHK("halt stop", 1'b0, proc_clk_run_o)
        intr_i <= 1'b1;
        wait_n(2);
        `CHK("intr wake", 1'b1, proc_clk_run_o)
        intr_i <= 1'b0;
        nmi_i <= 1'b1;
        halt_cycle_i <= 1'b1;
        @(posedge ref_clk_i);
        halt_cycle_i <= 1'b0;
        wait_n(3);
        `CHK("halt with nmi", 1'b1, proc_clk_run_o)
        nmi_i <= 1'b0;
        reg_wr(OFS_MODE, 8'h00);
        halt_cycle_i <= 1'b1;
        @(posedge ref_clk_i);
        halt_cycle_i <= 1'b0;
        wait_n(3);
        `CHK("halt disabled", 1'b1, proc_clk_run_o)
    endtask

    initial begin
        repeat (12) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        t_regs();
        t_select();
        t_size();
        t_refuse();
        t_stops();
        stop_test();
    end
endmodule // tb_top
